// File: include/wicr_pkg.sv
// shared constants for the wafer input crossbar router
package wicr_pkg;
  // wafer counts and crossbar shape
  localparam int WAFERS        = 32;      // wafers reachable by either device
  localparam int LOCAL_WAFERS  = 16;      // wafers landing on this device
  localparam int OUTS          = 16;      // crossbar outputs
  localparam int SEL_W         = 5;       // selector width, names one of 32 wafers
  localparam int UPPER_BASE    = 0;       // first wafer of the upper device
  localparam int LOWER_BASE    = 16;      // first wafer of the lower device
  localparam int OUTS_PER_POS  = 4;       // outputs feeding one recirculation position
  localparam int UPPER_POS     = 0;       // upper device feeds positions 0 to 3
  localparam int LOWER_POS     = 4;       // lower device feeds positions 4 to 7
  // clocking: bit clock is the reference multiplied up
  localparam int REF_MHZ       = 128;     // reference clock rate
  localparam int BIT_MHZ       = 1024;    // internal bit clock rate
  localparam int BITS_PER_REF  = BIT_MHZ / REF_MHZ; // bits per lane per reference cycle
  // phase alignment
  localparam int TAP_W         = 3;       // sampling phase tap select width
  localparam int GOOD_W        = 8;       // width of the good word counter
  // monitor bus register addresses
  localparam logic [3:0] ADDR_INDEX = 4'h0; // output index for selector access
  localparam logic [3:0] ADDR_SEL   = 4'h1; // staged selector of the indexed output
  localparam logic [3:0] ADDR_CTRL  = 4'h2; // clock source and apply strobe
  localparam logic [3:0] ADDR_PHASE = 4'h3; // phase sum source wafer and enable
  localparam logic [3:0] ADDR_LOCK0 = 4'h4; // lock flags, four bytes from here
  localparam logic [3:0] ADDR_ERR0  = 4'h8; // sticky error flags, four bytes from here
  localparam logic [3:0] ADDR_STAT  = 4'hc; // apply pending and alignment summary
  localparam logic [3:0] ADDR_ID    = 4'hd; // device identity
  // field positions
  localparam int CTRL_EXT_BIT  = 0;       // reference from external clock input
  localparam int CTRL_APPLY    = 1;       // write one to apply staged selectors
  localparam int PHASE_EN_BIT  = 5;       // phase sum enable
  localparam int STAT_PEND_BIT = 0;       // apply still waiting for a frame edge
  localparam int STAT_ALGN_BIT = 1;       // all local wafers aligned
  localparam int STAT_UPR_BIT  = 2;       // this device is the upper one
  // reset values
  localparam logic [7:0] ID_VALUE   = 8'h5a; // arbitrary identity value
  localparam logic [5:0] PHASE_RST  = 6'h00; // phase sum off after reset
  localparam logic [7:0] IDLE_WORD  = 8'h00; // unused frame lane sends zeros
endpackage : wicr_pkg

// File: logic/wicr_router.sv
// wafer input crossbar router: exchange, crossbar, alignment, status, monitor bus
`timescale 1ns/1ns
module wicr_router
  import wicr_pkg::*;
#(
  parameter int UPPER      = 1,              // 1 for the upper device, 0 for the lower
  parameter int WORD_W     = BITS_PER_REF,   // bits per wafer per reference cycle
  parameter int ALIGN_GOOD = 16              // clean words needed to declare alignment
) (
  input  wire logic                          clock,
  input  wire logic                          reset,
  input  wire logic                          link_clock,
  input  wire logic [LOCAL_WAFERS*WORD_W-1:0] local_wafer_data,
  input  wire logic [LOCAL_WAFERS-1:0]       local_wafer_par,
  input  wire logic [LOCAL_WAFERS-1:0]       local_rx_lock,
  input  wire logic                          local_frame_start,
  output logic      [LOCAL_WAFERS*TAP_W-1:0] align_tap,
  output logic      [LOCAL_WAFERS*WORD_W-1:0] partner_tx_data,
  output logic      [LOCAL_WAFERS-1:0]       partner_tx_lock,
  output logic      [LOCAL_WAFERS-1:0]       partner_tx_err,
  input  wire logic [LOCAL_WAFERS*WORD_W-1:0] partner_rx_data,
  input  wire logic [LOCAL_WAFERS-1:0]       partner_rx_lock,
  input  wire logic [LOCAL_WAFERS-1:0]       partner_rx_err,
  output logic      [OUTS*WORD_W-1:0]        out_wafer_data,
  output logic      [BITS_PER_REF-1:0]       frame_lane0,
  output logic      [BITS_PER_REF-1:0]       frame_lane1,
  output logic                               ref_clock_ext,
  input  wire logic                          mb_select,
  input  wire logic                          mb_write,
  input  wire logic                          mb_read,
  input  wire logic [3:0]                    monitor_bus_addr,
  input  wire logic [7:0]                    monitor_bus_data_in,
  output logic      [7:0]                    monitor_bus_data_out,
  output logic                               monitor_bus_data_oe
);

  localparam int LOCAL_BASE = (UPPER != 0) ? UPPER_BASE : LOWER_BASE;
  localparam int PEER_BASE  = (UPPER != 0) ? LOWER_BASE : UPPER_BASE;
  localparam int MB_W       = 3 + 4 + 8;   // select, write, read, address, data

  //////////////////////////////////////////////////////////////////////////////
  // link domain reset: asserted at once, released on the link clock
  logic link_rst_meta_r;                   // first stage, read only by second
  logic link_rst_r;                        // reset seen by link logic

  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) begin
      link_rst_meta_r <= 1'b1;
      link_rst_r      <= 1'b1;
    end else begin
      link_rst_meta_r <= 1'b0;
      link_rst_r      <= link_rst_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link domain: per-wafer phase alignment and error detection
  logic [LOCAL_WAFERS-1:0] aligned;        // tap settled on clean data
  logic [LOCAL_WAFERS-1:0] local_err;      // parity slip on an aligned wafer
  logic [LOCAL_WAFERS-1:0] local_lock;     // aligned and receiver locked

  genvar gi;
  generate
    for (gi = 0; gi < LOCAL_WAFERS; gi++) begin : g_align
      logic [TAP_W-1:0]  tap_r;            // current sampling phase
      logic [GOOD_W-1:0] good_r;           // clean words at this phase
      logic              algn_r;           // alignment reached
      logic              bad;              // parity mismatch this word
      assign bad = (^local_wafer_data[gi*WORD_W +: WORD_W]) != local_wafer_par[gi];
      // step the tap on every bad word, settle after a clean run
      always_ff @(posedge link_clock or posedge reset) begin
        if (reset) begin
          tap_r  <= '0;
          good_r <= '0;
          algn_r <= 1'b0;
        end else if (link_rst_r) begin
          tap_r  <= '0;
          good_r <= '0;
          algn_r <= 1'b0;
        end else if (bad) begin          // tracking: a slip restarts the search
          tap_r  <= tap_r + 1'b1;
          good_r <= '0;
          algn_r <= 1'b0;
        end else if (!algn_r) begin
          good_r <= good_r + 1'b1;
          algn_r <= (good_r == GOOD_W'(ALIGN_GOOD - 1));
        end
      end
      assign align_tap[gi*TAP_W +: TAP_W] = tap_r;
      assign aligned[gi]    = algn_r;
      assign local_err[gi]  = bad & algn_r;
      assign local_lock[gi] = algn_r & local_rx_lock[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // link domain: forward local wafers to the twin device
  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) begin
      partner_tx_data <= '0;
      partner_tx_lock <= '0;
      partner_tx_err  <= '0;
    end else begin
      partner_tx_data <= local_wafer_data;
      partner_tx_lock <= local_lock;
      partner_tx_err  <= local_err;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link domain: the full wafer space, local block at its own base
  logic [WORD_W-1:0] wafer_word [WAFERS];  // crossbar inputs by wafer number
  logic [WAFERS-1:0] wafer_lock;           // lock by wafer number
  logic [WAFERS-1:0] wafer_err;            // error pulse by wafer number

  generate
    for (gi = 0; gi < LOCAL_WAFERS; gi++) begin : g_space
      // own wafers keep their numbers, twin wafers fill the rest
      assign wafer_word[LOCAL_BASE+gi] = local_wafer_data[gi*WORD_W +: WORD_W];
      assign wafer_word[PEER_BASE+gi]  = partner_rx_data[gi*WORD_W +: WORD_W];
      assign wafer_lock[LOCAL_BASE+gi] = local_lock[gi];
      assign wafer_lock[PEER_BASE+gi]  = partner_rx_lock[gi];
      assign wafer_err[LOCAL_BASE+gi]  = local_err[gi];
      assign wafer_err[PEER_BASE+gi]   = partner_rx_err[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // link domain: apply staged selectors on a frame edge
  logic [SEL_W-1:0] shadow_sel_r [OUTS];   // staged in the system domain
  logic [5:0]       phase_r;               // staged phase sum control
  logic [SEL_W-1:0] active_sel_r [OUTS];   // selectors in use
  logic [5:0]       active_phase_r;        // phase sum control in use
  logic             req_tgl_r;             // system side apply request
  logic             req_meta_r;            // first stage, read only by second
  logic             req_sync_r;            // request seen on link clock
  logic             ack_tgl_r;             // link side apply done

  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) begin
      req_meta_r <= 1'b0;
      req_sync_r <= 1'b0;
    end else begin
      req_meta_r <= req_tgl_r;
      req_sync_r <= req_meta_r;
    end
  end

  // shadow stays frozen while a request is open, so it is safe to copy here
  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) begin
      ack_tgl_r      <= 1'b0;
      active_phase_r <= PHASE_RST;
      for (int k = 0; k < OUTS; k++) begin
        active_sel_r[k] <= SEL_W'(LOCAL_BASE + k);
      end
    end else if ((req_sync_r != ack_tgl_r) && local_frame_start) begin
      ack_tgl_r      <= req_sync_r;
      active_phase_r <= phase_r;
      for (int k = 0; k < OUTS; k++) begin
        active_sel_r[k] <= shadow_sel_r[k];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link domain: crossbar outputs, registered
  generate
    for (gi = 0; gi < OUTS; gi++) begin : g_xbar
      // output gi goes to recirculation position base + gi / 4
      always_ff @(posedge link_clock or posedge reset) begin
        if (reset) begin
          out_wafer_data[gi*WORD_W +: WORD_W] <= '0;
        end else begin
          out_wafer_data[gi*WORD_W +: WORD_W] <= wafer_word[active_sel_r[gi]];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // link domain: single phased stream onto the first frame lane
  logic [SEL_W-1:0] phase_src;             // the one wafer being summed
  assign phase_src = active_phase_r[SEL_W-1:0];

  // an unlocked source contributes nothing; no flow control is consulted
  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) begin
      frame_lane0 <= IDLE_WORD;
      frame_lane1 <= IDLE_WORD;
    end else begin
      if (active_phase_r[PHASE_EN_BIT] && wafer_lock[phase_src]) begin
        frame_lane0 <= BITS_PER_REF'(wafer_word[phase_src]);
      end else begin
        frame_lane0 <= IDLE_WORD;
      end
      frame_lane1 <= IDLE_WORD;            // second lane idles
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // link domain: error events as toggles for the system domain
  logic [WAFERS-1:0] err_tgl_r;            // flips once per error word

  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) begin
      err_tgl_r <= '0;
    end else begin
      err_tgl_r <= err_tgl_r ^ wafer_err;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: synchronisers for bus pins and link status
  logic [MB_W-1:0]   mb_meta_r;            // first stage, read only by second
  logic [MB_W-1:0]   mb_sync_r;            // bus pins on the system clock
  logic              mb_wr_prev_r;         // for the write edge
  logic              ack_meta_r;           // first stage, read only by second
  logic              ack_sync_r;           // apply done seen on system clock
  logic [WAFERS-1:0] lock_meta_r;          // first stage, read only by second
  logic [WAFERS-1:0] lock_sync_r;          // lock levels
  logic [WAFERS-1:0] err_meta_r;           // first stage, read only by second
  logic [WAFERS-1:0] err_sync_r;           // error toggles
  logic [WAFERS-1:0] err_prev_r;           // previous toggles for edges
  logic [LOCAL_WAFERS-1:0] algn_meta_r;    // first stage, read only by second
  logic [LOCAL_WAFERS-1:0] algn_sync_r;    // alignment levels

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mb_meta_r    <= '0;
      mb_sync_r    <= '0;
      mb_wr_prev_r <= 1'b0;
      ack_meta_r   <= 1'b0;
      ack_sync_r   <= 1'b0;
      lock_meta_r  <= '0;
      lock_sync_r  <= '0;
      err_meta_r   <= '0;
      err_sync_r   <= '0;
      err_prev_r   <= '0;
      algn_meta_r  <= '0;
      algn_sync_r  <= '0;
    end else begin
      mb_meta_r    <= {mb_select, mb_write, mb_read, monitor_bus_addr, monitor_bus_data_in};
      mb_sync_r    <= mb_meta_r;
      mb_wr_prev_r <= mb_sync_r[13];
      ack_meta_r   <= ack_tgl_r;
      ack_sync_r   <= ack_meta_r;
      lock_meta_r  <= wafer_lock;
      lock_sync_r  <= lock_meta_r;
      err_meta_r   <= err_tgl_r;
      err_sync_r   <= err_meta_r;
      err_prev_r   <= err_sync_r;
      algn_meta_r  <= aligned;
      algn_sync_r  <= algn_meta_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: monitor bus decode
  logic       bus_sel;                     // chip prefix already matched outside
  logic       bus_rd;                      // read strobe
  logic [3:0] bus_addr;                    // chip-local address
  logic [7:0] bus_wdata;                   // write data
  logic       wr_pulse;                    // one cycle per write
  assign bus_sel   = mb_sync_r[14];
  assign bus_rd    = mb_sync_r[12];
  assign bus_addr  = mb_sync_r[11:8];
  assign bus_wdata = mb_sync_r[7:0];
  assign wr_pulse  = bus_sel & mb_sync_r[13] & ~mb_wr_prev_r;

  //////////////////////////////////////////////////////////////////////////////
  // system domain: control registers and selector staging
  logic [3:0] index_r;                     // output picked for selector access
  logic       pend_r;                      // apply waiting for the link side
  logic       apply_wr;                    // apply strobe written this cycle
  assign apply_wr = wr_pulse && (bus_addr == ADDR_CTRL) && bus_wdata[CTRL_APPLY];

  // writes to the stage are dropped while an apply is open: the link side copies it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      index_r       <= '0;
      ref_clock_ext <= 1'b0;
      phase_r       <= PHASE_RST;
      for (int k = 0; k < OUTS; k++) begin
        shadow_sel_r[k] <= SEL_W'(LOCAL_BASE + k);
      end
    end else if (wr_pulse) begin
      case (bus_addr)
        ADDR_INDEX: index_r <= bus_wdata[3:0];
        ADDR_SEL: begin
          if (!pend_r) begin
            shadow_sel_r[index_r] <= bus_wdata[SEL_W-1:0];
          end
        end
        ADDR_CTRL: ref_clock_ext <= bus_wdata[CTRL_EXT_BIT]; // wafer or external
        ADDR_PHASE: begin
          if (!pend_r) begin
            phase_r <= bus_wdata[5:0];
          end
        end
        default: ;                         // error bytes clear in their own block, the rest are read only
      endcase
    end
  end

  // apply handshake: toggle out, wait for the matching toggle back
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      req_tgl_r <= 1'b0;
      pend_r    <= 1'b0;
    end else if (!pend_r && apply_wr) begin
      req_tgl_r <= ~req_tgl_r;
      pend_r    <= 1'b1;
    end else if (pend_r && (ack_sync_r == req_tgl_r)) begin
      pend_r    <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: sticky errors, write one to clear; a new error beats the clear
  logic [WAFERS-1:0] err_sticky_r;         // errors since last clear
  logic [WAFERS-1:0] err_clr;              // bits cleared by this write

  always_comb begin
    err_clr = '0;
    if (wr_pulse && (bus_addr[3:2] == ADDR_ERR0[3:2])) begin
      err_clr[bus_addr[1:0]*8 +: 8] = bus_wdata;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      err_sticky_r <= '0;
    end else begin
      err_sticky_r <= (err_sticky_r & ~err_clr) | (err_sync_r ^ err_prev_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system domain: read mux and data pin drive
  logic [7:0] rdata;                       // value for the current address

  always_comb begin
    rdata = 8'h00;
    case (bus_addr)
      ADDR_INDEX: rdata = {4'h0, index_r};
      ADDR_SEL:   rdata = {3'h0, shadow_sel_r[index_r]};
      ADDR_CTRL:  rdata = {7'h00, ref_clock_ext};
      ADDR_PHASE: rdata = {2'h0, phase_r};
      ADDR_STAT:  rdata = {5'h00, (UPPER != 0), &algn_sync_r, pend_r};
      ADDR_ID:    rdata = ID_VALUE;
      default: begin
        if (bus_addr[3:2] == ADDR_LOCK0[3:2]) begin
          rdata = lock_sync_r[bus_addr[1:0]*8 +: 8];
        end else if (bus_addr[3:2] == ADDR_ERR0[3:2]) begin
          rdata = err_sticky_r[bus_addr[1:0]*8 +: 8];
        end
      end
    endcase
  end

  // drive the shared data lines only while selected and reading
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      monitor_bus_data_out <= 8'h00;
      monitor_bus_data_oe  <= 1'b0;
    end else begin
      monitor_bus_data_out <= rdata;
      monitor_bus_data_oe  <= bus_sel & bus_rd;
    end
  end

endmodule : wicr_router

// File: bench/wicr_router_chk.sv
// port-level assertions for the wafer input crossbar router
`timescale 1ns/1ns
module wicr_router_chk
  import wicr_pkg::*;
(
  input wire logic         clock,
  input wire logic         reset,
  input wire logic         link_clock,
  input wire logic [127:0] local_wafer_data,
  input wire logic [15:0]  local_wafer_par,
  input wire logic [127:0] partner_tx_data,
  input wire logic [15:0]  partner_tx_err,
  input wire logic [7:0]   frame_lane1,
  input wire logic         ref_clock_ext,
  input wire logic         mb_select,
  input wire logic         mb_write,
  input wire logic         mb_read,
  input wire logic [3:0]   monitor_bus_addr,
  input wire logic [7:0]   monitor_bus_data_out,
  input wire logic         monitor_bus_data_oe
);
  logic [2:0]  lk_cnt_r; // link edges since reset, covers the synced link reset
  logic [15:0] bad_par;  // local words whose parity fails
  // count link edges so pipeline checks skip the reset tail
  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) lk_cnt_r <= 3'h0;
    else if (lk_cnt_r != 3'h7) lk_cnt_r <= lk_cnt_r + 3'h1;
  end
  // parity of each local word
  always_comb begin
    for (int i = 0; i < 16; i++) bad_par[i] = (^local_wafer_data[i*8+:8]) != local_wafer_par[i];
  end
  ////////////////////////////////////////////////////////////////////////
  property p_lane1_idle;
    @(posedge link_clock) disable iff (reset) frame_lane1 == IDLE_WORD;
  endproperty
  a_lane1_idle: assert property (p_lane1_idle)
    else $error("spare frame lane carries data");
  property p_tx_data;
    @(posedge link_clock) disable iff (reset)
      lk_cnt_r > 3'h4 |-> partner_tx_data == $past(local_wafer_data);
  endproperty
  a_tx_data: assert property (p_tx_data)
    else $error("twin exchange word wrong");
  property p_tx_err;
    @(posedge link_clock) disable iff (reset)
      lk_cnt_r > 3'h4 |-> (partner_tx_err & ~($past(bad_par) | $past(bad_par, 2))) == 16'h0;
  endproperty
  a_tx_err: assert property (p_tx_err)
    else $error("error pulse without bad parity");
  property p_oe_read;
    @(posedge clock) disable iff (reset) (mb_select && mb_read) [*4] |-> monitor_bus_data_oe;
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("data bus not driven during read");
  property p_oe_off;
    @(posedge clock) disable iff (reset) (!mb_read) [*4] |-> !monitor_bus_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data bus driven without read");
  property p_id;
    @(posedge clock) disable iff (reset)
      (mb_select && mb_read && monitor_bus_addr == ADDR_ID) [*4]
      |-> monitor_bus_data_out == ID_VALUE;
  endproperty
  a_id: assert property (p_id)
    else $error("identity read wrong");
  property p_unmapped;
    @(posedge clock) disable iff (reset)
      (mb_select && mb_read && monitor_bus_addr[3:1] == 3'h7) [*4]
      |-> monitor_bus_data_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_ref_stable;
    @(posedge clock) disable iff (reset) (!mb_write) [*4] |-> $stable(ref_clock_ext);
  endproperty
  a_ref_stable: assert property (p_ref_stable)
    else $error("clock source moved without write");
  c_err: cover property (@(posedge link_clock) disable iff (reset) partner_tx_err != 16'h0);
  c_ext: cover property (@(posedge clock) disable iff (reset) $rose(ref_clock_ext));
  c_read: cover property (@(posedge clock) disable iff (reset) monitor_bus_data_oe);
endmodule : wicr_router_chk
bind wicr_router wicr_router_chk u_chk (.clock, .reset, .link_clock, .local_wafer_data,
  .local_wafer_par, .partner_tx_data, .partner_tx_err, .frame_lane1, .ref_clock_ext,
  .mb_select, .mb_write, .mb_read, .monitor_bus_addr, .monitor_bus_data_out,
  .monitor_bus_data_oe);

// File: bench/wicr_twin_model.sv
// behavioural twin device feeding the remote wafers over the exchange lines
`timescale 1ns/1ns
module wicr_twin_model (
  input  wire logic         link_clock,
  input  wire logic         reset,
  output logic      [127:0] rx_data,
  output logic      [15:0]  rx_lock,
  output logic      [15:0]  rx_err
);
  // no flow control exists, the twin streams regardless
  assign rx_err = 16'h0;
  // fresh remote words every link cycle, locked once out of reset
  always_ff @(posedge link_clock or posedge reset) begin
    if (reset) begin
      rx_data <= '0;
      rx_lock <= 16'h0;
    end else begin
      rx_data <= {$urandom, $urandom, $urandom, $urandom};
      rx_lock <= 16'hffff;
    end
  end
endmodule : wicr_twin_model

// File: bench/wicr_router_tb.sv
// self-checking bench for the wafer input crossbar router
`timescale 1ns/1ns
module wicr_router_tb;
  import wicr_pkg::*;
  logic         clock = 1'b0;      // system clock
  logic         link_clock = 1'b0; // wafer side clock
  logic         reset = 1'b1;
  logic [127:0] lw_data = '0;      // local wafer words
  logic [15:0]  lw_par = '0;
  logic         frame_start = 1'b0;
  logic         inj = 1'b0;        // corrupt one parity bit of wafer 2
  logic         sel = 1'b0;
  logic         wr = 1'b0;
  logic         rd = 1'b0;
  logic [3:0]   addr = 4'h0;
  logic [7:0]   din = 8'h00;
  logic [7:0]   t, dout, lane0, lane1, ph_s;
  logic [127:0] rx_data, out_data;
  logic [15:0]  rx_lock, rx_err;
  logic [47:0]  tap;
  logic         ref_ext;
  logic [7:0]   w[32];             // words the design saw at the last link edge
  int           sel_m[16], stage[16], ph_src = 0, bad_count = 0, total_checks = 0, cycles = 0;
  bit           ph_en = 1'b0, chk_en = 1'b0;
  always #5 clock = ~clock;
  initial begin
    #3;
    forever #15 link_clock = ~link_clock;
  end
  wicr_twin_model u_twin (.link_clock, .reset, .rx_data, .rx_lock, .rx_err);
  wicr_router #(.UPPER(1), .ALIGN_GOOD(4)) u_dut (.clock, .reset, .link_clock,
    .local_wafer_data(lw_data), .local_wafer_par(lw_par), .local_rx_lock(16'hffff),
    .local_frame_start(frame_start), .align_tap(tap), .partner_tx_data(), .partner_tx_lock(),
    .partner_tx_err(), .partner_rx_data(rx_data), .partner_rx_lock(rx_lock),
    .partner_rx_err(rx_err), .out_wafer_data(out_data), .frame_lane0(lane0),
    .frame_lane1(lane1), .ref_clock_ext(ref_ext), .mb_select(sel), .mb_write(wr),
    .mb_read(rd), .monitor_bus_addr(addr), .monitor_bus_data_in(din),
    .monitor_bus_data_out(dout), .monitor_bus_data_oe());
  ////////////////////////////////////////////////////////////////////////
  // capture what the design samples, then launch new words with even parity
  always @(posedge link_clock) begin
    for (int i = 0; i < 16; i++) begin
      w[i] = lw_data[i*8+:8];
      w[i+16] = rx_data[i*8+:8];
      t = 8'($urandom);
      lw_data[i*8+:8] <= t;
      lw_par[i] <= (^t) ^ (inj && i == 2);
    end
  end
  // model comparison half a link cycle after each result
  always @(negedge link_clock) begin
    if (chk_en) begin
      for (int k = 0; k < 16; k++) cmp_word(out_data[k*8+:8], w[sel_m[k]]);
      cmp_word(lane0, ph_en ? w[ph_src] : 8'h00);
      cmp_word(lane1, IDLE_WORD);
    end
  end
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic cmp_word(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t link word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t register %h expected %h", $time, got, exp);
    end
  endtask : cmp_reg
  // bus write: hold four clocks, then idle four so the synchronisers settle
  // chip prefix is decoded outside, sel stands for it
  task automatic mb_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    sel <= 1'b1;
    wr <= 1'b1;
    addr <= a;
    din <= d;
    repeat (4) @(posedge clock);
    wr <= 1'b0;
    sel <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : mb_wr
  task automatic mb_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    sel <= 1'b1;
    rd <= 1'b1;
    addr <= a;
    repeat (4) @(posedge clock);
    d = dout;
    rd <= 1'b0;
    sel <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : mb_rd
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    mb_rd(a, d);
    cmp_reg(d, exp);
  endtask : rd_chk
  // apply staged selectors at a frame edge; a write while pending must be dropped
  task automatic apply(input logic ext);
    logic [7:0] d;
    d = 8'hff;
    chk_en = 1'b0;
    mb_wr(ADDR_CTRL, {6'h0, 1'b1, ext});
    rd_chk(ADDR_STAT, 8'h07);
    cmp_reg({7'h0, ref_ext}, {7'h0, ext});
    mb_wr(ADDR_SEL, 8'h1f);
    @(posedge link_clock);
    frame_start <= 1'b1;
    @(posedge link_clock);
    frame_start <= 1'b0;
    for (int n = 0; n < 10 && d[0] !== 1'b0; n++) mb_rd(ADDR_STAT, d);
    cmp_reg(d, 8'h06);
    sel_m = stage;
    ph_en = ph_s[5];
    ph_src = ph_s[4:0];
    repeat (3) @(posedge link_clock);
    chk_en = 1'b1;
    repeat (20) @(posedge link_clock);
  endtask : apply
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h5306));
    for (int k = 0; k < 16; k++) sel_m[k] = k;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    repeat (12) @(posedge link_clock);
    chk_en = 1'b1;
    mb_wr(ADDR_ID, 8'h00);
    rd_chk(ADDR_ID, ID_VALUE);
    rd_chk(4'he, 8'h00);
    for (int a = 4; a < 8; a++) rd_chk(4'(a), 8'hff);
    // random routes with a forced fan-out on outputs 0 and 1
    for (int r = 0; r < 5; r++) begin
      for (int k = 0; k < 16; k++) begin
        stage[k] = (k == 1) ? stage[0] : $urandom_range(31);
        mb_wr(ADDR_INDEX, 8'(k));
        mb_wr(ADDR_SEL, 8'(stage[k]));
      end
      ph_s = 8'($urandom) & 8'h3f;
      mb_wr(ADDR_PHASE, ph_s);
      apply(r[0]);
    end
    // one bad parity word on wafer 2 while aligned
    chk_en = 1'b0;
    @(posedge link_clock);
    inj <= 1'b1;
    @(posedge link_clock);
    inj <= 1'b0;
    repeat (12) @(posedge link_clock);
    cmp_reg({5'h0, tap[8:6]}, 8'h01);
    rd_chk(ADDR_ERR0, 8'h04);
    mb_wr(ADDR_ERR0, 8'h04);
    rd_chk(ADDR_ERR0, 8'h00);
    tally_and_finish;
  end
endmodule : wicr_router_tb
